// ### verilog/rplo_rx_out.sv
// Receive parallel output stage: four lanes of code groups are decoded
// or passed raw and presented with a byte per lane clock edge; with sync select high, lanes 1-3 take bytes on lane 0 edges.
// Assumes recovered clocks and code groups arrive from the serial side,
// asynchronous to mclk_i, with a recovered clock much slower than mclk_i.
`timescale 1ns/10ps
`default_nettype none

module rplo_rx_out (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic lane_clock_sync_sel_i,
  input wire logic decode_mode_i,
  input wire logic [3:0] rec_clk_i,
  input wire logic [39:0] code_group_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic rx_clk_lane0_o,
  output logic rx_clk_lane1_o,
  output logic rx_clk_lane2_o,
  output logic rx_clk_lane3_o,
  output logic [7:0] rx_byte_lane0_o,
  output logic [7:0] rx_byte_lane1_o,
  output logic [7:0] rx_byte_lane2_o,
  output logic [7:0] rx_byte_lane3_o,
  output logic rx_ctrl_flag_lane0_o,
  output logic rx_ctrl_flag_lane1_o,
  output logic rx_ctrl_flag_lane2_o,
  output logic rx_ctrl_flag_lane3_o,
  output logic rx_err_flag_lane0_o,
  output logic rx_err_flag_lane1_o,
  output logic rx_err_flag_lane2_o,
  output logic rx_err_flag_lane3_o
);

  // ----------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------
  // 6-bit sub-block abcdei (a in MSB) to {valid, EDCBA}
  function automatic logic [5:0] dec6(input logic [5:0] s);
    logic [5:0] r;
    r = 6'h00;
    unique case (s)
      6'h27, 6'h18: r = 6'h20;
      6'h1D, 6'h22: r = 6'h21;
      6'h2D, 6'h12: r = 6'h22;
      6'h31: r = 6'h23;
      6'h35, 6'h0A: r = 6'h24;
      6'h29: r = 6'h25;
      6'h19: r = 6'h26;
      6'h38, 6'h07: r = 6'h27;
      6'h39, 6'h06: r = 6'h28;
      6'h25: r = 6'h29;
      6'h15: r = 6'h2A;
      6'h34: r = 6'h2B;
      6'h0D: r = 6'h2C;
      6'h2C: r = 6'h2D;
      6'h1C: r = 6'h2E;
      6'h17, 6'h28: r = 6'h2F;
      6'h1B, 6'h24: r = 6'h30;
      6'h23: r = 6'h31;
      6'h13: r = 6'h32;
      6'h32: r = 6'h33;
      6'h0B: r = 6'h34;
      6'h2A: r = 6'h35;
      6'h1A: r = 6'h36;
      6'h3A, 6'h05: r = 6'h37;
      6'h33, 6'h0C: r = 6'h38;
      6'h26: r = 6'h39;
      6'h16: r = 6'h3A;
      6'h36, 6'h09: r = 6'h3B;
      6'h0E, 6'h0F, 6'h30: r = 6'h3C;
      6'h2E, 6'h11: r = 6'h3D;
      6'h1E, 6'h21: r = 6'h3E;
      6'h2B, 6'h14: r = 6'h3F;
      default: r = 6'h00;  // Not a legal sub-block
    endcase
    return r;
  endfunction : dec6

  // 4-bit sub-block fghj (f in MSB) to {valid, HGF}
  function automatic logic [3:0] dec4(input logic [3:0] s);
    logic [3:0] r;
    r = 4'h0;
    unique case (s)
      4'hB, 4'h4: r = 4'h8;
      4'h9: r = 4'h9;
      4'h5: r = 4'hA;
      4'hC, 4'h3: r = 4'hB;
      4'hD, 4'h2: r = 4'hC;
      4'hA: r = 4'hD;
      4'h6: r = 4'hE;
      4'hE, 4'h1, 4'h7, 4'h8: r = 4'hF;
      default: r = 4'h0;  // All ones or all zeros
    endcase
    return r;
  endfunction : dec4

  // Sub-blocks that turn a trailing alternate 7 into a K-character
  function automatic logic k7_head(input logic [5:0] s);
    logic r;
    r = 1'b0;
    unique case (s)
      6'h3A, 6'h05, 6'h36, 6'h09: r = 1'b1;
      6'h2E, 6'h11, 6'h1E, 6'h21: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : k7_head

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  logic [3:0] clk_s;      // Recovered clocks, synced
  logic [39:0] cg_s;      // Code groups, synced with the same delay
  logic [1:0] pins_s;     // {decode mode, lane clock select}
  logic sync_sel;         // Lanes 1-3 timed by lane 0
  logic decode_mode;      // High: decoded bytes and flags

  // Data and clock pass equal delays so a group taken at a
  // synced edge is the one that stood at the real edge
  rplo_sync #(.W(4)) u_sync_clk (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i(rec_clk_i),
    .q_o(clk_s)
  );

  rplo_sync #(.W(40)) u_sync_cg (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i(code_group_i),
    .q_o(cg_s)
  );

  rplo_sync #(.W(2)) u_sync_pin (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i({decode_mode_i, lane_clock_sync_sel_i}),
    .q_o(pins_s)
  );

  assign sync_sel = pins_s[0];
  assign decode_mode = pins_s[1];

  // ----------------------------------------------------------
  // Edge tracking
  // ----------------------------------------------------------
  logic [3:0] clk_d;      // Previous synced clock level
  logic [3:0] edge_now;   // Either edge of a recovered clock
  logic [3:0] edge_d1;    // Edge, one cycle later: load stage
  logic [3:0] edge_d2;    // Edge, two cycles later: flip clock

  assign edge_now = clk_s ^ clk_d;

  // Delay line that spaces data ahead of the output clock edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_d <= 4'h0;
      edge_d1 <= 4'h0;
      edge_d2 <= 4'h0;
    end else begin
      clk_d <= clk_s;
      edge_d1 <= edge_now;
      edge_d2 <= edge_d1;
    end
  end

  // ----------------------------------------------------------
  // Per-lane decode and output
  // ----------------------------------------------------------
  logic [3:0] rd_q;          // Running disparity, high is positive
  logic [3:0] err_evt;       // Decode error seen at an edge
  logic [7:0] byte_w [4];    // Output stage bytes
  logic [3:0] ctrl_w;        // Output stage bit 8
  logic [3:0] err_w;         // Output stage bit 9
  logic [3:0] clk_w;         // Output stage clocks
  logic [3:0] next_rd;       // Disparity after the current group

  for (genvar n = 0; n < rplo_pkg::LANES; n++) begin : g_lane
    logic [9:0] cg;         // Group, bit 0 is a
    logic [5:0] s6;         // abcdei
    logic [3:0] s4;         // fghj
    logic [3:0] s4_k;       // fghj, folded for K28 at RD+
    logic [5:0] d6;         // {valid, EDCBA}
    logic [3:0] d4;         // {valid, HGF}
    logic [2:0] n6;         // Ones in s6
    logic [2:0] n4;         // Ones in s4
    logic rd_mid;           // Disparity between sub-blocks
    logic bad6;             // 6-bit disparity violation
    logic bad4;             // 4-bit disparity violation
    logic is_k;             // Special character
    logic dec_err;          // Any decode fault
    logic [9:0] raw_word;   // Undecoded output word
    logic [9:0] dec_word;   // Decoded output word
    logic [9:0] word_q;     // Latest group, held per lane
    logic take;             // Selected clock edge, delayed
    rplo_lane_if lane_bus ();

    assign cg = cg_s[n*10 +: 10];  // Synced copy only; the raw pin is never read
    assign s6 = {cg[0], cg[1], cg[2], cg[3], cg[4], cg[5]};
    assign s4 = {cg[6], cg[7], cg[8], cg[9]};
    // K28 at RD+ carries the inverted fghj of its RD- form
    assign s4_k = (s6 == rplo_pkg::K28_POS) ? ~s4 : s4;
    assign d6 = dec6(s6);
    assign d4 = dec4(s4_k);
    assign n6 = 3'($countones(s6));
    assign n4 = 3'($countones(s4));

    // A positive block needs RD-, a negative one RD+
    assign bad6 = (n6 == 3'd4 && rd_q[n]) || (n6 == 3'd2 && !rd_q[n])
      || (s6 == rplo_pkg::D7_NEG && rd_q[n])
      || (s6 == rplo_pkg::D7_POS && !rd_q[n]);
    assign rd_mid = (n6 == 3'd4) ? 1'b1 : (n6 == 3'd2) ? 1'b0 : rd_q[n];
    assign bad4 = (n4 == 3'd3 && rd_mid) || (n4 == 3'd1 && !rd_mid)
      || (s4 == rplo_pkg::X3_NEG && rd_mid)
      || (s4 == rplo_pkg::X3_POS && !rd_mid);
    // An unbalanced 4-bit block holds three ones (positive) or one (negative)
    assign next_rd[n] = (n4 == 3'd3) ? 1'b1 : (n4 == 3'd1) ? 1'b0 : rd_mid;

    // K28.y, or Kx.7 where the alternate 7 follows its head
    assign is_k = (s6 == rplo_pkg::K28_NEG) || (s6 == rplo_pkg::K28_POS)
      || (k7_head(s6) && (s4 == rplo_pkg::A7_NEG || s4 == rplo_pkg::A7_POS));
    assign dec_err = !d6[5] || !d4[3] || bad6 || bad4;

    assign raw_word = cg;
    assign dec_word = {dec_err, is_k && !dec_err, d4[2:0], d6[4:0]};
    assign err_evt[n] = edge_now[n] && decode_mode && dec_err;

    // Capture the group and advance disparity at each own edge
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        word_q <= rplo_pkg::WORD_RST;
        rd_q[n] <= rplo_pkg::RD_RST[n];
      end else if (edge_now[n]) begin
        word_q <= decode_mode ? dec_word : raw_word;
        rd_q[n] <= next_rd[n];
      end
    end

    // Lane 0 always uses its own edges; others follow the select
    if (n == 0) begin : g_lead
      assign take = edge_d1[0];
    end else begin : g_follow
      assign take = sync_sel ? edge_d1[0] : edge_d1[n];
    end

    assign lane_bus.load = take;
    assign lane_bus.clk_evt = edge_d2[n];
    assign lane_bus.word = word_q;

    rplo_lane_out u_out (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .bus(lane_bus.dst),
      .byte_o(byte_w[n]),
      .ctrl_o(ctrl_w[n]),
      .err_o(err_w[n]),
      .clk_o(clk_w[n])
    );
  end

  // ----------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------
  assign rx_clk_lane0_o = clk_w[0];
  assign rx_clk_lane1_o = clk_w[1];
  assign rx_clk_lane2_o = clk_w[2];
  assign rx_clk_lane3_o = clk_w[3];
  assign rx_byte_lane0_o = byte_w[0];
  assign rx_byte_lane1_o = byte_w[1];
  assign rx_byte_lane2_o = byte_w[2];
  assign rx_byte_lane3_o = byte_w[3];
  assign rx_ctrl_flag_lane0_o = ctrl_w[0];
  assign rx_ctrl_flag_lane1_o = ctrl_w[1];
  assign rx_ctrl_flag_lane2_o = ctrl_w[2];
  assign rx_ctrl_flag_lane3_o = ctrl_w[3];
  assign rx_err_flag_lane0_o = err_w[0];
  assign rx_err_flag_lane1_o = err_w[1];
  assign rx_err_flag_lane2_o = err_w[2];
  assign rx_err_flag_lane3_o = err_w[3];

  // ----------------------------------------------------------
  // Register port
  // ----------------------------------------------------------
  logic [3:0] status_q;    // Sticky decode errors per lane
  logic [3:0] mask_q;      // Interrupt enables per lane
  logic hit_status;        // Address decodes
  logic hit_mask;
  logic hit_info;
  logic [3:0] w1c;         // Bits software clears this cycle
  logic [31:0] info_w;     // Live state word
  logic [31:0] rd_mux;     // Selected read word

  assign hit_status = reg_addr_i == rplo_pkg::ADDR_STATUS;
  assign hit_mask = reg_addr_i == rplo_pkg::ADDR_MASK;
  assign hit_info = reg_addr_i == rplo_pkg::ADDR_INFO;
  assign w1c = (reg_wr_i && hit_status) ? reg_wdata_i[3:0] : 4'h0;

  assign info_w = (32'(rd_q) << rplo_pkg::INFO_RD_LSB)
    | (32'(sync_sel) << rplo_pkg::INFO_SYNC_BIT)
    | (32'(decode_mode) << rplo_pkg::INFO_MODE_BIT);

  // Unmapped addresses read as zero
  assign rd_mux = hit_status ? {28'h0000000, status_q}
    : hit_mask ? {28'h0000000, mask_q}
    : hit_info ? info_w : 32'h00000000;

  // A new error in the clearing cycle survives the clear
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_q <= rplo_pkg::STATUS_RST;
    end else begin
      status_q <= (status_q & ~w1c) | err_evt;
    end
  end

  // Mask register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= rplo_pkg::MASK_RST;
    end else if (reg_wr_i && hit_mask) begin
      mask_q <= reg_wdata_i[3:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

  assign irq_o = |(status_q & mask_q);

endmodule : rplo_rx_out

`default_nettype wire

// ### inc/rplo_pkg.sv
// Constants shared by the receive parallel lane output stage.
// Assumes a single 25 MHz core clock and a plain register port.
package rplo_pkg;

  // ----------------------------------------------------------
  // Structure
  // ----------------------------------------------------------
  localparam int LANES = 4;           // Channels 0..3
  localparam int CG_W = 10;           // Code group width
  localparam int BYTE_W = 8;          // Data byte width
  localparam int ADDR_W = 4;          // Register address width
  localparam int DATA_W = 32;         // Register data width
  localparam int CG_NINTH = 8;        // Ninth code bit position
  localparam int CG_TENTH = 9;        // Tenth code bit position

  // ----------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;  // Sticky decode errors, W1C
  localparam logic [3:0] ADDR_MASK = 4'h4;    // Interrupt enables
  localparam logic [3:0] ADDR_INFO = 4'h8;    // Live state, read only

  // ----------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------
  localparam int INFO_RD_LSB = 0;     // Running disparity per lane
  localparam int INFO_SYNC_BIT = 4;   // Synced lane clock select
  localparam int INFO_MODE_BIT = 5;   // Synced decode mode
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] RD_RST = 4'h0;        // Start at negative disparity
  localparam logic [9:0] WORD_RST = 10'h000;

  // ----------------------------------------------------------
  // Special code sub-blocks
  // ----------------------------------------------------------
  localparam logic [5:0] K28_NEG = 6'h0F;     // abcdei of K28, RD-
  localparam logic [5:0] K28_POS = 6'h30;     // abcdei of K28, RD+
  localparam logic [5:0] D7_NEG = 6'h38;      // Neutral, only at RD-
  localparam logic [5:0] D7_POS = 6'h07;      // Neutral, only at RD+
  localparam logic [3:0] X3_NEG = 4'hC;       // Neutral, only at RD-
  localparam logic [3:0] X3_POS = 4'h3;       // Neutral, only at RD+
  localparam logic [3:0] A7_NEG = 4'h8;       // Alternate 7 after RD-
  localparam logic [3:0] A7_POS = 4'h7;       // Alternate 7 after RD+

endpackage : rplo_pkg

// ### inc/rplo_lane_if.sv
// One lane's hand-off from the decode core to its output stage.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none

interface rplo_lane_if;
  logic load;          // One-cycle pulse: take a new word
  logic clk_evt;       // One-cycle pulse: flip the lane clock
  logic [9:0] word;    // {err, ctrl, byte}

  modport src (output load, output clk_evt, output word);
  modport dst (input load, input clk_evt, input word);
endinterface : rplo_lane_if

`default_nettype wire

// ### verilog/rplo_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level from outside the core clock domain.
`timescale 1ns/10ps
`default_nettype none

module rplo_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------
  // Flop chain
  // ----------------------------------------------------------
  logic [W-1:0] meta;  // First stage, read by the second only

  // Two stages; nothing taps the first
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : rplo_sync

`default_nettype wire

// ### verilog/rplo_lane_out.sv
// Output register of one lane: ten data bits and a regenerated clock.
// Assumes load and clk_evt are core clock pulses from the decode core.
`timescale 1ns/10ps
`default_nettype none

module rplo_lane_out (
  input wire logic mclk_i,
  input wire logic rstn_i,
  rplo_lane_if.dst bus,
  output logic [7:0] byte_o,
  output logic ctrl_o,
  output logic err_o,
  output logic clk_o
);

  // ----------------------------------------------------------
  // Output word
  // ----------------------------------------------------------
  logic [9:0] word_q;  // All ten bits held as one register

  // Whole word moves in one step so flags never split from data
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_q <= rplo_pkg::WORD_RST;
    end else if (bus.load) begin
      word_q <= bus.word;
    end
  end

  // ----------------------------------------------------------
  // Lane clock
  // ----------------------------------------------------------
  // Each flip is one output edge; data loaded by the same edge settles a cycle before it
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_o <= 1'b0;
    end else if (bus.clk_evt) begin
      clk_o <= ~clk_o;
    end
  end

  assign byte_o = word_q[7:0];
  assign ctrl_o = word_q[rplo_pkg::CG_NINTH];
  assign err_o = word_q[rplo_pkg::CG_TENTH];

endmodule : rplo_lane_out

`default_nettype wire

// ### bench/rplo_lane_src.sv
// Serial-side source: recovered lane clocks and the code groups they carry.
// Assumes the caller waits for each send to return before the next one.
`timescale 1ns/10ps
`default_nettype none

module rplo_lane_src (
  output logic [3:0] rec_clk_o,
  output logic [39:0] code_group_o
);
  // Clocks stand still between groups; the first edge comes from low
  initial begin
    rec_clk_o = 4'h0;
    code_group_o = 40'h0;
  end

  // One group per edge; three core cycles of setup and hold either side
  // stretch the half period, traded for a clean capture window
  task automatic send(input logic [3:0] lanes, input logic [39:0] grp);
    #7;
    code_group_o = grp;
    #120;
    rec_clk_o = rec_clk_o ^ lanes;
    #120;
    code_group_o = ~grp; // Hold time over: stale data must not linger
  endtask : send
endmodule : rplo_lane_src

`default_nettype wire

// ### bench/rplo_rx_out_chk.sv
// Port checker for the receive parallel lane output stage.
// Assumes it is bound to rplo_rx_out and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module rplo_rx_out_chk (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic lane_clock_sync_sel_i,
  input wire logic decode_mode_i,
  input wire logic [3:0] rec_clk_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic rx_clk_lane0_o,
  input wire logic rx_clk_lane1_o,
  input wire logic rx_clk_lane3_o,
  input wire logic [7:0] rx_byte_lane0_o,
  input wire logic [7:0] rx_byte_lane1_o,
  input wire logic [7:0] rx_byte_lane2_o,
  input wire logic rx_ctrl_flag_lane0_o,
  input wire logic rx_err_flag_lane0_o,
  input wire logic rx_err_flag_lane3_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // ----
  // Lane timing
  // ----
  lane0_edge_a: assert property ($changed(rx_byte_lane0_o) |=> $changed(rx_clk_lane0_o))
    else $error("lane 0 byte moved without a clock edge");
  clk_cause_a: assert property (
    $changed(rx_clk_lane0_o) |-> $past(rec_clk_i[0], 2) != $past(rec_clk_i[0], 7))
    else $error("lane 0 clock flipped without a recovered edge");
  own_clk_a: assert property (
    !lane_clock_sync_sel_i && $changed(rx_byte_lane1_o) |=> $changed(rx_clk_lane1_o))
    else $error("lane 1 byte moved off its own clock");
  lane0_timed_a: assert property (
    lane_clock_sync_sel_i && $changed(rx_byte_lane2_o) |=> $changed(rx_clk_lane0_o))
    else $error("lane 2 byte moved off the lane 0 clock");
  flag_follow_a: assert property (
    !lane_clock_sync_sel_i && $changed(rx_err_flag_lane3_o) |=> $changed(rx_clk_lane3_o))
    else $error("lane 3 error flag moved off its own clock");
  group_whole_a: assert property ($changed(rx_err_flag_lane0_o) |=> $changed(rx_clk_lane0_o))
    else $error("lane 0 flag moved apart from its group");

  // ----
  // Decode flags and registers
  // ----
  k_err_excl_a: assert property (
    $changed({rx_err_flag_lane0_o, rx_ctrl_flag_lane0_o}) && decode_mode_i
    && $past(decode_mode_i, 6) |-> !(rx_ctrl_flag_lane0_o && rx_err_flag_lane0_o))
    else $error("K flag raised on an errored group");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the read answer cycle");
  mask_off_a: assert property (
    reg_wr_i && reg_addr_i == rplo_pkg::ADDR_MASK && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt high with all sources masked");
endmodule : rplo_rx_out_chk

bind rplo_rx_out rplo_rx_out_chk u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .lane_clock_sync_sel_i(lane_clock_sync_sel_i),
  .decode_mode_i(decode_mode_i), .rec_clk_i(rec_clk_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .rx_clk_lane0_o(rx_clk_lane0_o),
  .rx_clk_lane1_o(rx_clk_lane1_o), .rx_clk_lane3_o(rx_clk_lane3_o),
  .rx_byte_lane0_o(rx_byte_lane0_o), .rx_byte_lane1_o(rx_byte_lane1_o),
  .rx_byte_lane2_o(rx_byte_lane2_o), .rx_ctrl_flag_lane0_o(rx_ctrl_flag_lane0_o),
  .rx_err_flag_lane0_o(rx_err_flag_lane0_o), .rx_err_flag_lane3_o(rx_err_flag_lane3_o)
);

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the receive parallel lane output stage.
// Assumes the lane source model and the port checker are compiled too.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ----
  // Stimulus and observed signals
  // ----
  localparam logic [9:0] K_NEG = 10'h17C; // K28.5, negative disparity, a at bit 0
  localparam logic [9:0] K_POS = 10'h283; // K28.5, positive disparity
  localparam logic [9:0] D21 = 10'h155; // D21.5, neutral
  localparam logic [39:0] RAW_A = {10'h0FF, 10'h2C3, 10'h15A, 10'h3A5};
  localparam logic [39:0] RAW_B = {10'h1E1, 10'h30C, 10'h0A6, 10'h25B};
  localparam logic [39:0] RAW_C = {10'h3C0, 10'h06F, 10'h2D2, 10'h13D};
  logic mclk, rstn, sync_sel, dec_mode, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr, lclk, lctrl, lerr, rec_clk;
  logic [31:0] reg_wdata, reg_rdata;
  logic [39:0] cgrp;
  logic [7:0] lbyte [4];
  int miscompares = 0;
  int cmp_count = 0;
  logic [3:0] exp_lclk = 4'h0; // Expected lane clock levels, one flip per sent edge

  rplo_lane_src src (.rec_clk_o(rec_clk), .code_group_o(cgrp));

  rplo_rx_out uut (
    .mclk_i(mclk), .rstn_i(rstn), .lane_clock_sync_sel_i(sync_sel),
    .decode_mode_i(dec_mode), .rec_clk_i(rec_clk), .code_group_i(cgrp),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .irq_o(irq),
    .rx_clk_lane0_o(lclk[0]), .rx_clk_lane1_o(lclk[1]),
    .rx_clk_lane2_o(lclk[2]), .rx_clk_lane3_o(lclk[3]),
    .rx_byte_lane0_o(lbyte[0]), .rx_byte_lane1_o(lbyte[1]),
    .rx_byte_lane2_o(lbyte[2]), .rx_byte_lane3_o(lbyte[3]),
    .rx_ctrl_flag_lane0_o(lctrl[0]), .rx_ctrl_flag_lane1_o(lctrl[1]),
    .rx_ctrl_flag_lane2_o(lctrl[2]), .rx_ctrl_flag_lane3_o(lctrl[3]),
    .rx_err_flag_lane0_o(lerr[0]), .rx_err_flag_lane1_o(lerr[1]),
    .rx_err_flag_lane2_o(lerr[2]), .rx_err_flag_lane3_o(lerr[3])
  );

  // 25 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----
  // Compare tasks
  // ----
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk_reg

  // Lanes are compared as {err, ctrl, byte}; the mask drops don't-care bits
  task automatic chk_lanes(input logic [39:0] exp, input logic [9:0] msk);
    logic [9:0] got;
    for (int n = 0; n < 4; n++) begin
      got = {lerr[n], lctrl[n], lbyte[n]} & msk;
      cmp_count++;
      if (got !== (exp[10*n +: 10] & msk)) begin
        miscompares++;
        $display("CHECK FAILED lane %0d word exp %h got %h", n, exp[10*n +: 10] & msk, got);
      end
    end
  endtask : chk_lanes

  // ----
  // Register bus and lane tasks
  // ----
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp,
                      input logic [31:0] msk);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(nm, exp & msk, reg_rdata & msk);
  endtask : rchk

  // Outputs settle within five core cycles of the lane clock edge
  task automatic send_chk(input logic [3:0] l, input logic [39:0] g, input logic [39:0] exp,
                          input logic [9:0] msk);
    src.send(l, g);
    repeat (3) @(posedge mclk);
    chk_lanes(exp, msk);
    exp_lclk = exp_lclk ^ l;
    chk_reg("lane clocks", {28'h0, exp_lclk}, {28'h0, lclk});
  endtask : send_chk

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ----
  // Test sequence
  // ----
  initial begin
    rstn = 1'b0;
    sync_sel = 1'b0;
    dec_mode = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rchk("status", rplo_pkg::ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
    rchk("mask", rplo_pkg::ADDR_MASK, 32'h0, 32'hFFFFFFFF);
    rchk("unmapped", 4'hC, 32'h0, 32'hFFFFFFFF);
    rchk("info", rplo_pkg::ADDR_INFO, 32'h20, 32'h30);
    // Decoded mode: K flag, then disparity and invalid-code errors
    send_chk(4'hF, {4{K_NEG}}, {4{10'h1BC}}, 10'h3FF);
    send_chk(4'hF, {4{K_POS}}, {4{10'h1BC}}, 10'h3FF);
    send_chk(4'hF, {4{D21}}, {4{10'h0B5}}, 10'h3FF);
    send_chk(4'hF, {K_POS, D21, 10'h000, K_POS}, {10'h200, 10'h0B5, 10'h200, 10'h200},
             10'h300);
    chk_reg("irq", 32'h0, {31'h0, irq});
    rchk("status", rplo_pkg::ADDR_STATUS, 32'hB, 32'hFFFFFFFF);
    wr(rplo_pkg::ADDR_MASK, 32'h2);
    #1 chk_reg("irq", 32'h1, {31'h0, irq});
    rchk("mask", rplo_pkg::ADDR_MASK, 32'h2, 32'hFFFFFFFF);
    wr(rplo_pkg::ADDR_STATUS, 32'h2);
    #1 chk_reg("irq", 32'h0, {31'h0, irq});
    rchk("status", rplo_pkg::ADDR_STATUS, 32'h9, 32'hFFFFFFFF);
    wr(rplo_pkg::ADDR_MASK, 32'h0);
    wr(rplo_pkg::ADDR_INFO, 32'hFFFFFFFF);
    rchk("info", rplo_pkg::ADDR_INFO, 32'h20, 32'h30);
    // Raw mode: all ten code bits pass straight through
    dec_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    send_chk(4'hF, RAW_A, RAW_A, 10'h3FF);
    send_chk(4'hF, ~RAW_A, ~RAW_A, 10'h3FF);
    // Sync select high: lanes 1-3 wait for a lane 0 edge
    sync_sel <= 1'b1;
    repeat (4) @(posedge mclk);
    send_chk(4'hE, RAW_B, ~RAW_A, 10'h3FF);
    send_chk(4'h1, RAW_C, {RAW_B[39:10], RAW_C[9:0]}, 10'h3FF);
    // Sync select low again: lanes 1-3 back on their own clocks
    sync_sel <= 1'b0;
    repeat (4) @(posedge mclk);
    send_chk(4'hE, RAW_A, {RAW_A[39:10], RAW_C[9:0]}, 10'h3FF);
    conclude();
  end

  // Watchdog: the sequence needs well under 20 us
  initial begin
    #100000;
    miscompares++;
    $display("watchdog expired");
    conclude();
  end
endmodule : tb_top

`default_nettype wire
